// File: sim/eight_bit_async_timer_counter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module eight_bit_async_timer_counter_bench;
  import tc8_pkg::*;
  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic [5:0]  adr     = '0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = '0;
  logic [3:0]  be      = '0;
  logic [31:0] rdata;
  logic        wreq;
  logic        xtal    = 1'b0;
  logic        mtr     = 1'b0;
  logic        wave;
  logic [2:0]  irq;
  logic [7:0]  cyc     = '0;
  logic [7:0]  v;
  logic [7:0]  r;
  int          num_errors = 0;
  int          n_compared = 0;
  int          dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [5:0]  offs[10] = '{OFS_CTLA, OFS_CTLB, OFS_CNT, OFS_OCA, OFS_OCB,
                            OFS_FLAG, OFS_MASK, OFS_ASYNC, OFS_PWR, 6'h24};

  always #10 ref_clk = ~ref_clk;

  // Slow pins run free: crystal rises every 8 cycles, meter pin every 16
  always @(posedge ref_clk)
  begin
    cyc  <= cyc + 8'h01;
    xtal <= cyc[2];
    mtr  <= cyc[3];
  end

  tc8_timer dut (
    .ref_clk           (ref_clk),
    .nrst              (nrst),
    .avs_address       (adr),
    .avs_read          (rd),
    .avs_write         (wr),
    .avs_writedata     (wd),
    .avs_byteenable    (be),
    .avs_readdata      (rdata),
    .avs_waitrequest   (wreq),
    .crystal_pin_in    (xtal),
    .meter_reading_pin (mtr),
    .wave_out_a        (wave),
    .int_req           (irq)
  );

  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] b, output logic [7:0] q);
    adr <= a;
    wr  <= w;
    rd  <= ~w;
    wd  <= {24'h000000, d};
    be  <= b;
    @(posedge ref_clk);
    while (wreq !== 1'b0)
      @(posedge ref_clk);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    // One idle edge keeps a following request from reassigning in this step
    @(posedge ref_clk);
  endtask : bus

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, 4'h1, q);
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] q);
    bus(a, 1'b0, 8'h00, 4'h0, q);
  endtask : rd_reg

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic chk_in(input string s, input int lo, input int hi, input logic [8:0] g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      num_errors++;
      $display("unexpected %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask : chk_in

  function automatic int pwm_high(input int ocr, input bit inv);
    return inv ? 255 - ocr : ocr + 1;
  endfunction : pwm_high

  task automatic run(input logic [7:0] ctlb, input int n);
    wr_reg(OFS_CTLB, ctlb);
    repeat (n) @(posedge ref_clk);
    wr_reg(OFS_CTLB, 8'h00);
  endtask : run

  // Start from zero, run n cycles, then compare the count against a window
  task automatic tick_test(input logic [7:0] asel, input logic [7:0] ctlb, input int n,
                           input int lo, input int hi);
    logic [7:0] q;
    wr_reg(OFS_ASYNC, asel);
    wr_reg(OFS_CNT, 8'h00);
    run(ctlb, n);
    rd_reg(OFS_CNT, q);
    chk_in("count", lo, hi, 9'(q));
    wr_reg(OFS_ASYNC, 8'h00);
  endtask : tick_test

  task automatic pwm_test(input logic [7:0] ctla, input int e);
    int hi;
    wr_reg(OFS_CTLA, ctla);
    wr_reg(OFS_CTLB, 8'h01);
    repeat (300) @(posedge ref_clk);
    hi = 0;
    repeat (256)
    begin
      @(posedge ref_clk);
      hi += int'(wave === 1'b1);
    end
    wr_reg(OFS_CTLB, 8'h00);
    chk_in("pwm high time", e - 2, e + 2, 9'(hi));
  endtask : pwm_test

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    $display("unexpected watchdog expected finish seen hang");
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'ha43d07ad));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    wr_reg(6'h24, 8'hA5);
    foreach (offs[i])
      begin
        rd_reg(offs[i], v);
        chk("reset value", 8'h00, v);
      end
    done("reset");
    for (int i = 0; i < 4; i++)
    begin
      r = 8'($urandom);
      wr_reg(OFS_CNT, r);
      wr_reg(OFS_OCB, ~r);
      repeat (5) @(posedge ref_clk);
      rd_reg(OFS_CNT, v);
      chk("stopped count", r, v);
      rd_reg(OFS_OCB, v);
      chk("compare b", ~r, v);
    end
    bus(OFS_CNT, 1'b1, ~r, 4'h0, v);
    rd_reg(OFS_CNT, v);
    chk("count lane off", r, v);
    done("access");
    for (int c = 1; c < 8; c++)
      tick_test(8'h00, 8'(c), dv[c] * 20, 18, 24);
    tick_test(8'h20, 8'h01, 160, 17, 24);
    tick_test(8'h60, 8'h01, 160, 8, 13);
    wr_reg(OFS_PWR, 8'h01);
    tick_test(8'h00, 8'h01, 100, 0, 0);
    wr_reg(OFS_PWR, 8'h00);
    done("clock");
    wr_reg(OFS_MASK, 8'h07);
    wr_reg(OFS_OCA, 8'hF4);
    wr_reg(OFS_OCB, 8'hF8);
    wr_reg(OFS_CNT, 8'hF0);
    run(8'h01, 30);
    rd_reg(OFS_FLAG, v);
    chk("normal flags", 8'h07, v);
    chk("int request", 8'h07, {5'h00, irq});
    rd_reg(OFS_CNT, v);
    chk_in("normal wrap", 16, 22, 9'(v));
    wr_reg(OFS_MASK, 8'h02);
    wr_reg(OFS_FLAG, 8'h05);
    rd_reg(OFS_FLAG, v);
    chk("flag clear", 8'h02, v);
    chk("masked request", 8'h02, {5'h00, irq});
    wr_reg(OFS_FLAG, 8'h07);
    done("normal");
    wr_reg(OFS_CTLA, 8'h02);
    r = 8'h10 + 8'($urandom_range(47));
    wr_reg(OFS_OCA, r);
    wr_reg(OFS_CNT, 8'h00);
    run(8'h01, 300);
    rd_reg(OFS_CNT, v);
    chk_in("match clear", 0, int'(r), 9'(v));
    rd_reg(OFS_FLAG, v);
    chk("match flags", 8'h02, v);
    wr_reg(OFS_FLAG, 8'h07);
    wr_reg(OFS_CNT, 8'h80);
    run(8'h01, 140);
    rd_reg(OFS_FLAG, v);
    chk("late top wrap", 8'h05, v & 8'h05);
    wr_reg(OFS_OCA, 8'h30);
    wr_reg(OFS_FLAG, 8'h07);
    done("clear on match");
    wr_reg(OFS_CTLA, 8'h01);
    wr_reg(OFS_CNT, 8'h00);
    run(8'h09, 400);
    rd_reg(OFS_CNT, v);
    chk_in("dual slope top", 0, 48, 9'(v));
    rd_reg(OFS_FLAG, v);
    chk("bottom overflow", 8'h01, v & 8'h01);
    done("phase correct");
    wr_reg(OFS_CTLA, 8'h02);
    wr_reg(OFS_OCA, 8'h40);
    pwm_test(8'h83, pwm_high(64, 1'b0));
    pwm_test(8'hC3, pwm_high(64, 1'b1));
    done("fast pwm");
    report_and_stop();
  end
endmodule : eight_bit_async_timer_counter_bench
`default_nettype wire

// File: src/tc8_pkg.sv
package tc8_pkg;
  localparam int unsigned AW = 6;

  localparam logic [5:0] OFS_CTLA  = 6'h00;
  localparam logic [5:0] OFS_CTLB  = 6'h04;
  localparam logic [5:0] OFS_CNT   = 6'h08;
  localparam logic [5:0] OFS_OCA   = 6'h0C;
  localparam logic [5:0] OFS_OCB   = 6'h10;
  localparam logic [5:0] OFS_FLAG  = 6'h14;
  localparam logic [5:0] OFS_MASK  = 6'h18;
  localparam logic [5:0] OFS_ASYNC = 6'h1C;
  localparam logic [5:0] OFS_PWR   = 6'h20;

  localparam int unsigned COMA_LSB  = 6;
  localparam int unsigned COMB_LSB  = 4;
  localparam int unsigned WGMLO_LSB = 0;
  localparam int unsigned WGM2_BIT  = 3;
  localparam int unsigned CS_LSB    = 0;
  localparam int unsigned FLG_OVF   = 0;
  localparam int unsigned FLG_MA    = 1;
  localparam int unsigned FLG_MB    = 2;
  localparam int unsigned WAVA_BIT  = 0;
  localparam int unsigned WAVB_BIT  = 1;
  localparam int unsigned AS_BIT    = 5;
  localparam int unsigned AMR_BIT   = 6;
  localparam int unsigned PWR_BIT   = 0;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam logic [2:0] CS_OFF     = 3'h0;

  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TGL = 2'h1;
  localparam logic [1:0] COM_CLR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Prescaler masks: a tick fires when all masked bits are one
  localparam logic [9:0] PS_DIV1    = 10'h000;
  localparam logic [9:0] PS_DIV8    = 10'h007;
  localparam logic [9:0] PS_DIV32   = 10'h01F;
  localparam logic [9:0] PS_DIV64   = 10'h03F;
  localparam logic [9:0] PS_DIV128  = 10'h07F;
  localparam logic [9:0] PS_DIV256  = 10'h0FF;
  localparam logic [9:0] PS_DIV1024 = 10'h3FF;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_PC_FF    = 3'b001,
    MODE_CTC      = 3'b010,
    MODE_FAST_FF  = 3'b011,
    MODE_RSV4     = 3'b100,
    MODE_PC_OCA   = 3'b101,
    MODE_RSV6     = 3'b110,
    MODE_FAST_OCA = 3'b111
  } tc8_mode_t;
endpackage : tc8_pkg

// File: src/tc8_tick.sv
`timescale 1ns/10ps
`default_nettype none
module tc8_tick (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       async_clock_select,
  input  wire logic       meter_select,
  input  wire logic       crystal_pin_in,
  input  wire logic       meter_reading_pin,
  output logic            timer_tick
);
  import tc8_pkg::*;

  typedef struct packed {
    logic [9:0] pre;
    logic       s1;
    logic       s2;
    logic       s3;
  } tc8_tick_t;

  tc8_tick_t  q;
  tc8_tick_t  d;
  logic       base;
  logic [9:0] msk;

  always_comb
  begin
    d = q;
    d.s1 = meter_select ? meter_reading_pin : crystal_pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Slow pin clock is sampled; each rising edge is one base step
    base = async_clock_select ? (q.s2 & ~q.s3) : 1'b1;
    if (base)
      d.pre = q.pre + 10'h001;
    case (clock_select_field)
      3'h1:    msk = PS_DIV1;
      3'h2:    msk = PS_DIV8;
      3'h3:    msk = PS_DIV32;
      3'h4:    msk = PS_DIV64;
      3'h5:    msk = PS_DIV128;
      3'h6:    msk = PS_DIV256;
      3'h7:    msk = PS_DIV1024;
      default: msk = PS_DIV1;
    endcase
    timer_tick = base && (clock_select_field != CS_OFF) && ((q.pre & msk) == msk);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end
endmodule : tc8_tick
`default_nettype wire

// File: src/tc8_timer.sv
// Contract
// - Overflow and two match flags in one register, each gated by a mask bit.
// - Timer clock is the bus clock unless async select picks crystal or meter pin.
// - Clock select zero gives no ticks; the counter stays stopped.
// - Count is readable and writable always; a write beats clear or count.
// - Each tick clears, increments or decrements the counter per waveform mode.
// - Internal count, direction, clear controls; top and bottom indications produced.
// - Both compare values matched against counter on every tick; match sets flag, drives wave.
// - Bottom is 0x00, maximum is 0xFF.
// - Top is 0xFF or compare value A depending on mode.
// - Mode is two low bits in control A plus high bit in control B.
// - Modes: 0 normal, 1/5 phase-correct, 2 clear-on-match, 3/7 fast, 4/6 reserved.
// - Compare load immediate in modes 0,2; at top 1,3,5,7.
// - Overflow at max in 0,2,3; at bottom in 1,5; at top in 7.
// - Output mode fields never change the counting sequence.
// - Output mode selects polarity in PWM, set/clear/toggle otherwise.
// - Channel B wave exists internally but drives no pin.
// - Normal mode only increments, wraps 0xFF to 0x00, overflow on wrap.
// - Clear-on-match clears at compare A; a lower value lets it wrap first.
// - Fast PWM changes output on match and at top-to-bottom.
// - Phase-correct counts up, turns at top without holding, down; clears up-match, sets down-match.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tc8_timer (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic [tc8_pkg::AW-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  crystal_pin_in,
  input  wire logic                  meter_reading_pin,
  output logic                       wave_out_a,
  output logic [2:0]                 int_req
);
  import tc8_pkg::*;

  typedef struct packed {
    logic [7:0]  ctla;
    logic [3:0]  ctlb;
    logic [7:0]  cnt;
    logic [7:0]  buf_a;
    logic [7:0]  buf_b;
    logic [7:0]  act_a;
    logic [7:0]  act_b;
    logic [2:0]  flags;
    logic [2:0]  mask;
    logic        as_sel;
    logic        amr_sel;
    logic        pwr_off;
    logic        dir_up;
    logic        wav_a;
    logic        wav_b;
    logic        done;
    logic [31:0] rdata;
  } tc8_state_t;

  tc8_state_t q;
  tc8_state_t d;
  tc8_mode_t  mode;
  logic       tick_raw;
  logic       tick;
  logic       wen;
  logic       cnt_wr;
  logic       is_pc;
  logic       is_fast;
  logic       at_top;
  logic       at_bot;
  logic       match_a;
  logic       match_b;
  logic       ovf;
  logic       upd;
  logic [7:0] top;
  logic [7:0] cnt_nx;
  logic       dir_nx;
  logic [7:0] wd;

  tc8_tick u_tick (
    .ref_clk            (ref_clk),
    .nrst               (nrst),
    .clock_select_field (q.ctlb[CS_LSB +: 3]),
    .async_clock_select (q.as_sel),
    .meter_select       (q.amr_sel),
    .crystal_pin_in     (crystal_pin_in),
    .meter_reading_pin  (meter_reading_pin),
    .timer_tick         (tick_raw)
  );

  // Output-mode fields only enter here, never the count path
  function automatic logic wave_nx(
    input logic [1:0] com,
    input logic       cur,
    input logic       mt,
    input logic       bot,
    input logic       up,
    input logic       fast,
    input logic       pc
  );
    logic r;
    r = cur;
    if (fast)
    begin
      if (com == COM_CLR)
        r = bot ? 1'b1 : (mt ? 1'b0 : cur);
      else if (com == COM_SET)
        r = bot ? 1'b0 : (mt ? 1'b1 : cur);
      else if (com == COM_TGL && mt)
        r = ~cur;
    end
    else if (pc)
    begin
      if (mt && com == COM_CLR)
        r = ~up;
      else if (mt && com == COM_SET)
        r = up;
    end
    else if (mt)
    begin
      case (com)
        COM_TGL: r = ~cur;
        COM_CLR: r = 1'b0;
        COM_SET: r = 1'b1;
        default: r = cur;
      endcase
    end
    return r;
  endfunction : wave_nx

  always_comb
  begin
    d = q;
    wd = avs_writedata[7:0];
    avs_waitrequest = (avs_read | avs_write) & ~q.done;
    wen = avs_write & q.done & avs_byteenable[0];
    cnt_wr = wen && (avs_address == OFS_CNT);
    // Power-off gates the tick, so the counter and flags freeze
    tick = tick_raw & ~q.pwr_off;
    mode = tc8_mode_t'({q.ctlb[WGM2_BIT], q.ctla[WGMLO_LSB +: 2]});
    is_pc = (mode == MODE_PC_FF) || (mode == MODE_PC_OCA);
    is_fast = (mode == MODE_FAST_FF) || (mode == MODE_FAST_OCA);
    if (mode == MODE_CTC || mode == MODE_PC_OCA || mode == MODE_FAST_OCA)
      top = q.act_a;
    else
      top = CNT_MAX;
    at_top = (q.cnt == top);
    at_bot = (q.cnt == CNT_BOTTOM);
    dir_nx = q.dir_up;
    if (is_pc)
    begin
      if (q.dir_up && at_top)
      begin
        cnt_nx = q.cnt - CNT_ONE;
        dir_nx = 1'b0;
      end
      else if (!q.dir_up && at_bot)
      begin
        cnt_nx = q.cnt + CNT_ONE;
        dir_nx = 1'b1;
      end
      else if (q.dir_up)
        cnt_nx = q.cnt + CNT_ONE;
      else
        cnt_nx = q.cnt - CNT_ONE;
    end
    else
    begin
      dir_nx = 1'b1;
      // A lower compare A is missed; plain increment wraps past 0xFF
      cnt_nx = at_top ? CNT_BOTTOM : q.cnt + CNT_ONE;
    end
    match_a = tick && (q.cnt == q.act_a);
    match_b = tick && (q.cnt == q.act_b);
    case (mode)
      MODE_NORMAL, MODE_CTC, MODE_FAST_FF: ovf = tick && (q.cnt == CNT_MAX);
      MODE_PC_FF, MODE_PC_OCA:             ovf = tick && !q.dir_up && (q.cnt == CNT_ONE);
      MODE_FAST_OCA:                       ovf = tick && at_top;
      default:                             ovf = 1'b0;
    endcase
    if (tick && !cnt_wr)
    begin
      d.cnt = cnt_nx;
      d.dir_up = dir_nx;
    end
    d.wav_a = wave_nx(q.ctla[COMA_LSB +: 2], q.wav_a, match_a, tick && at_top, q.dir_up, is_fast, is_pc);
    d.wav_b = wave_nx(q.ctla[COMB_LSB +: 2], q.wav_b, match_b, tick && at_top, q.dir_up, is_fast, is_pc);
    d.flags = q.flags;
    if (wen && avs_address == OFS_FLAG)
      d.flags = q.flags & ~avs_writedata[2:0];
    d.flags[FLG_OVF] = d.flags[FLG_OVF] | ovf;
    d.flags[FLG_MA] = d.flags[FLG_MA] | match_a;
    d.flags[FLG_MB] = d.flags[FLG_MB] | match_b;
    if (wen)
    begin
      case (avs_address)
        OFS_CTLA:  d.ctla = wd;
        OFS_CTLB:  d.ctlb = wd[3:0];
        OFS_CNT:   d.cnt = wd;
        OFS_OCA:   d.buf_a = wd;
        OFS_OCB:   d.buf_b = wd;
        OFS_MASK:  d.mask = wd[2:0];
        OFS_ASYNC:
        begin
          d.as_sel = wd[AS_BIT];
          d.amr_sel = wd[AMR_BIT];
        end
        OFS_PWR:   d.pwr_off = wd[PWR_BIT];
        default:   d.done = q.done;
      endcase
    end
    // Non-PWM modes track the buffer; PWM modes reload once per period
    upd = (!is_pc && !is_fast) || (tick && at_top);
    if (upd)
    begin
      d.act_a = d.buf_a;
      d.act_b = d.buf_b;
    end
    d.done = (avs_read | avs_write) & ~q.done;
    if (avs_read && !q.done)
    begin
      d.rdata = '0;
      case (avs_address)
        OFS_CTLA:  d.rdata[7:0] = q.ctla;
        OFS_CTLB:  d.rdata[3:0] = q.ctlb;
        OFS_CNT:   d.rdata[7:0] = q.cnt;
        OFS_OCA:   d.rdata[7:0] = q.buf_a;
        OFS_OCB:   d.rdata[7:0] = q.buf_b;
        OFS_FLAG:  d.rdata[2:0] = q.flags;
        OFS_MASK:  d.rdata[2:0] = q.mask;
        OFS_ASYNC:
        begin
          d.rdata[AS_BIT] = q.as_sel;
          d.rdata[AMR_BIT] = q.amr_sel;
          d.rdata[WAVA_BIT] = q.wav_a;
          d.rdata[WAVB_BIT] = q.wav_b;
        end
        OFS_PWR:   d.rdata[PWR_BIT] = q.pwr_off;
        default:   d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  assign avs_readdata = q.rdata;
  assign wave_out_a = q.wav_a;
  assign int_req = q.flags & q.mask;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_stop_holds: assert property ((q.ctlb[CS_LSB +: 3] == CS_OFF) && !cnt_wr |=> $stable(q.cnt))
    else $error("counter moved with no clock selected");
  a_write_wins: assert property (cnt_wr |=> q.cnt == $past(avs_writedata[7:0]))
    else $error("count write lost");
  a_norm_wrap: assert property (mode == MODE_NORMAL && tick && q.cnt == CNT_MAX && !cnt_wr
                                |=> q.cnt == CNT_BOTTOM && q.flags[FLG_OVF])
    else $error("normal wrap or overflow wrong");
  a_ctc_clear: assert property (mode == MODE_CTC && tick && q.cnt == q.act_a && !cnt_wr
                                |=> q.cnt == CNT_BOTTOM)
    else $error("no clear on match");
  a_pc_turn: assert property (is_pc && tick && q.dir_up && at_top && !cnt_wr
                              |=> !q.dir_up && q.cnt == $past(top) - CNT_ONE)
    else $error("phase-correct turnaround wrong");
  a_match_flag: assert property (match_a |=> q.flags[FLG_MA])
    else $error("match flag not set");
  a_req_gate: assert property (!q.mask[FLG_MB] |-> !int_req[FLG_MB])
    else $error("masked request visible");
  a_imm_load: assert property (mode == MODE_NORMAL && wen && avs_address == OFS_OCA
                               |=> q.act_a == $past(avs_writedata[7:0]))
    else $error("immediate compare load missing");
  a_pc_ovf: assert property (is_pc && tick && !q.dir_up && q.cnt == CNT_ONE |=> q.flags[FLG_OVF])
    else $error("bottom overflow missing");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  // Single-slope modes must always leave the direction pointing up
  a_dir_single: assert property (!is_pc && tick && !cnt_wr |=> q.dir_up)
    else $error("single-slope direction wrong");
  a_norm_step: assert property (mode == MODE_NORMAL && tick && !cnt_wr
                                |=> q.cnt == $past(q.cnt) + CNT_ONE)
    else $error("normal mode step wrong");
  a_fast_bottom: assert property (is_fast && tick && at_top && !cnt_wr |=> q.cnt == CNT_BOTTOM)
    else $error("fast mode did not restart");
  a_fast_set: assert property (is_fast && q.ctla[COMA_LSB +: 2] == COM_CLR && tick && at_top
                               |=> q.wav_a)
    else $error("fast wave not set at bottom");
  // Buffered compare must not leak into the active copy mid-period
  a_pwm_hold: assert property ((is_pc || is_fast) && !(tick && at_top) |=> $stable(q.act_a))
    else $error("compare reloaded mid-period");
  a_pwm_reload: assert property ((is_pc || is_fast) && tick && at_top && !(wen && avs_address == OFS_OCA)
                                 |=> q.act_a == $past(q.buf_a))
    else $error("compare not reloaded at top");
  a_max_ovf: assert property (mode == MODE_FAST_FF && tick && q.cnt == CNT_MAX
                              |=> q.flags[FLG_OVF])
    else $error("overflow at max missing");
  a_top_ovf: assert property (mode == MODE_FAST_OCA && tick && at_top |=> q.flags[FLG_OVF])
    else $error("overflow at top missing");
  // Reserved codes count but never raise overflow
  a_rsv_quiet: assert property ((mode == MODE_RSV4 || mode == MODE_RSV6) |-> !ovf)
    else $error("reserved mode raised overflow");
  a_match_b: assert property (match_b |=> q.flags[FLG_MB])
    else $error("match flag b not set");
  a_reset_zero: assert property ($rose(nrst) |-> q.cnt == CNT_BOTTOM && q.ctlb == 4'h0
                                 && q.flags == 3'h0)
    else $error("state not cleared by reset");
  a_pc_bottom: assert property (is_pc && tick && !q.dir_up && at_bot && !cnt_wr
                                |=> q.dir_up && q.cnt == CNT_ONE)
    else $error("phase-correct bottom turn wrong");

  c_norm_wrap: cover property (mode == MODE_NORMAL && tick && q.cnt == CNT_MAX);
  c_ctc_clear: cover property (mode == MODE_CTC && match_a);
  c_pc_turn: cover property (is_pc && tick && q.dir_up && at_top);
  c_fast_rise: cover property (is_fast && !q.wav_a ##1 q.wav_a);
  c_pc_ovf: cover property (is_pc && ovf);
endmodule : tc8_timer
`default_nettype wire
